// >>> rtl/wdt_defines.vh
/*
 * Constants of the watchdog timeout unit: register offsets, field
 * positions, reset values, timing figures and clock mode codes.
 * Assumes it is included by bare name from the rtl/ design files.
 */
`ifndef WDT_DEFINES_VH
`define WDT_DEFINES_VH

// timing: nominal timeout without prescaler, watchdog clock rate
`define WDT_PERIOD_MS 18
`define WDT_CLK_KHZ 50000
// 18 ms at 50000 cycles per ms, sized so the 20-bit parameter takes it whole
`define WDT_TIMEOUT_CYC 20'd900000
`define WDT_CNT_W 20
`define WDT_PS_W 7

// register byte offsets on the apb
`define WDT_ADDR_W 8
`define WDT_OFS_OPTION 8'h00
`define WDT_OFS_FLAGS 8'h04
`define WDT_OFS_IRQ_STAT 8'h08
`define WDT_OFS_IRQ_MASK 8'h0c
`define WDT_OFS_COUNT 8'h10

// timer_option_control fields and reset
`define WDT_OPTION_RST 8'hff
`define WDT_OPT_PSA 3
`define WDT_OPT_PS_HI 2
`define WDT_OPT_PS_LO 0

// flags register fields
`define WDT_FLG_TIMEOUT 0
`define WDT_FLG_POWERDOWN 1
`define WDT_FLG_SLEEPING 2
`define WDT_FLG_OSTHOLD 3
`define WDT_FLG_ENABLED 4

// interrupt status / mask fields and reset
`define WDT_IRQ_W 3
`define WDT_IRQ_RSTEXP 0
`define WDT_IRQ_WAKEEXP 1
`define WDT_IRQ_SLEEP 2
`define WDT_IRQ_RST 3'h0
`define WDT_MASK_RST 3'h0

// system clock mode codes; the three crystal modes need start-up time
`define WDT_CLK_LOWPOWER 3'h0
`define WDT_CLK_MEDIUM 3'h1
`define WDT_CLK_FAST 3'h2
`define WDT_CLK_EXTERNAL_RC_CLOCK 3'h3
`define WDT_CLK_INTERNAL_RC_CLOCK 3'h4
`define WDT_CLK_EXTERNAL_CLOCK_INPUT 3'h5
`define WDT_CLK_SECOSC 3'h6

`endif

// >>> rtl/wdt_sync.v
/*
 * Two-stage level synchroniser for signals from outside the mclk domain.
 * Assumes slow levels; pulses narrower than one mclk period may be lost.
 */
`default_nettype none

module wdt_sync #(
	parameter WIDTH = 1
) (
	// clock and reset
	input wire mclk,
	input wire rst_n,
	// asynchronous level in, synchronised level out
	input wire [WIDTH-1:0] asyncIn,
	output wire [WIDTH-1:0] syncOut
);

	reg [WIDTH-1:0] stage1_q;
	reg [WIDTH-1:0] stage2_q;

	always @(posedge mclk) begin
		if (!rst_n) begin
			stage1_q <= {WIDTH{1'b0}};
			stage2_q <= {WIDTH{1'b0}};
		end else begin
			stage1_q <= asyncIn;
			stage2_q <= stage1_q;
		end
	end

	assign syncOut = stage2_q;

endmodule

`default_nettype wire

// >>> rtl/wdt_counter.v
/*
 * Watchdog prescaler and timeout counter on the watchdog's own clock.
 * Assumes clearCount comes from logic on the same clock.
 */
`default_nettype none
`include "wdt_defines.vh"

module wdt_counter #(
	parameter [`WDT_CNT_W-1:0] TIMEOUT_CYCLES = `WDT_TIMEOUT_CYC
) (
	// clock and reset
	input wire mclk,
	input wire rst_n,
	// control
	input wire clearCount,
	input wire prescaleAssign,
	input wire [2:0] prescaleSel,
	// status
	output reg expire,
	output wire [`WDT_CNT_W-1:0] countValue
);

	reg [`WDT_PS_W-1:0] prescale_q;
	reg [`WDT_CNT_W-1:0] count_q;
	wire [`WDT_PS_W-1:0] tapMask;
	wire tick;

	// ratio 1:2^sel, so sel 7 gives 1:128
	function [`WDT_PS_W-1:0] psMask;
		input [2:0] sel;
		begin
			psMask = ~({`WDT_PS_W{1'b1}} << sel);
		end
	endfunction

	assign tapMask = psMask(prescaleSel);
	assign tick = prescaleAssign ? ((prescale_q & tapMask) == tapMask) :
		1'b1;
	assign countValue = count_q;

	// mclk here stands for the private free-running oscillator; it is
	// never gated by sleep (see [R1]) (see [R2])
	always @(posedge mclk) begin
		if (!rst_n) begin
			prescale_q <= {`WDT_PS_W{1'b0}}; // see [R14]
			count_q <= {`WDT_CNT_W{1'b0}};
			expire <= 1'b0;
		end else if (clearCount) begin
			// prescaler only belongs to us when assigned
			if (prescaleAssign)
				prescale_q <= {`WDT_PS_W{1'b0}}; // see [R8]
			count_q <= {`WDT_CNT_W{1'b0}};
			expire <= 1'b0;
		end else begin
			if (prescaleAssign)
				prescale_q <= prescale_q + {{(`WDT_PS_W-1){1'b0}}, 1'b1};
			expire <= 1'b0;
			if (tick) begin
				if (count_q == TIMEOUT_CYCLES - {{(`WDT_CNT_W-1){1'b0}},
					1'b1}) begin
					count_q <= {`WDT_CNT_W{1'b0}};
					expire <= 1'b1; // see [R6] (see [R7])
				end else begin
					count_q <= count_q + {{(`WDT_CNT_W-1){1'b0}}, 1'b1};
				end
			end
		end
	end

endmodule

`default_nettype wire

// >>> rtl/wdt_top.v
/*
 * Watchdog timeout unit: apb register file, sleep/wake sequencing,
 * timeout reset and wake requests, status flags and interrupt.
 * Assumes core instruction strobes are one-cycle pulses on mclk and the
 * configuration enable arrives asynchronously from the fuse block.
 */
// Chosen here: the APB slave port and the register addresses.
//
// Overview of operation
// [R1] The counter runs on its own free-running oscillator with no parts.
// [R2] Counting goes on while the processor clock is stopped in sleep.
// [R3] Expiry while running asks for a full device reset.
// [R4] Expiry while sleeping wakes the device instead of resetting it.
// [R5] A cleared configuration enable keeps the watchdog cleared forever.
// [R6] With no prescaler the timeout is 18 ms of the watchdog clock.
// [R7] The option register can give it a prescaler up to 1:128 (~2.3 s).
// [R8] Clear and sleep instructions zero the counter and its prescaler.
// [R9] Each timeout clears the timeout flag.
// [R10] Disable, clear, oscillator fail and non-crystal wake hold it clear.
// [R11] Wake in a crystal mode holds it clear until start-up time ends.
// [R12] Every wake from sleep clears the counter.
// [R13] Sleep entry clears the powerdown flag and sets the timeout flag.
// [R14] Any reset clears the counter and prescaler for a full period.
`default_nettype none
`include "wdt_defines.vh"

module wdt_top #(
	parameter [`WDT_CNT_W-1:0] TIMEOUT_CYCLES = `WDT_TIMEOUT_CYC
) (
	// clock and reset
	input wire mclk,
	input wire rst_n,
	// apb slave
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [`WDT_ADDR_W-1:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	// core strobes and clock system status
	input wire clearWatchdogInstruction,
	input wire sleepInstruction,
	input wire wakeSourceEvent,
	input wire oscFailDetect,
	input wire [2:0] sysClkMode,
	input wire oscillatorStartupTimerDone,
	input wire watchdogConfigEnable,
	// results
	output reg deviceResetReq,
	output reg wakeRequest,
	output reg sleeping,
	output reg timeoutFlag,
	output reg powerdownFlag,
	output reg [7:0] timerOption,
	output reg irq
);

	localparam [1:0] ST_RUN = 2'd0;
	localparam [1:0] ST_SLEEP = 2'd1;
	localparam [1:0] ST_OSTWAIT = 2'd2;

	reg [1:0] state_q;
	reg [1:0] state_d;
	reg [`WDT_IRQ_W-1:0] irqStat_q;
	reg [`WDT_IRQ_W-1:0] irqStat_d;
	reg [`WDT_IRQ_W-1:0] irqMask_q;
	reg [7:0] option_d;
	reg timeout_d;
	reg powerdown_d;
	reg resetReq_d;
	reg wakeReq_d;
	reg clearNow;
	reg [31:0] readValue;
	reg readHit;

	wire cfgEnable;
	wire expire;
	wire [`WDT_CNT_W-1:0] countValue;
	wire apbAccess;
	wire apbWrite;
	wire expireHit;
	wire wakeNow;
	wire [`WDT_IRQ_W-1:0] irqEvents;

	// crystal modes need the start-up timer before the clock is usable
	function isCrystal;
		input [2:0] mode;
		begin
			isCrystal = (mode == `WDT_CLK_LOWPOWER) ||
				(mode == `WDT_CLK_MEDIUM) || (mode == `WDT_CLK_FAST);
		end
	endfunction

	// one address decode for both the read and the write path
	function isReg;
		input [`WDT_ADDR_W-1:0] addr;
		input [`WDT_ADDR_W-1:0] ofs;
		begin
			isReg = (addr == ofs);
		end
	endfunction

	wdt_sync #(
		.WIDTH(1)
	) u_cfgSync (
		.mclk(mclk),
		.rst_n(rst_n),
		.asyncIn(watchdogConfigEnable),
		.syncOut(cfgEnable)
	);

	wdt_counter #(
		.TIMEOUT_CYCLES(TIMEOUT_CYCLES)
	) u_counter (
		.mclk(mclk),
		.rst_n(rst_n),
		.clearCount(clearNow),
		.prescaleAssign(timerOption[`WDT_OPT_PSA]),
		.prescaleSel(timerOption[`WDT_OPT_PS_HI:`WDT_OPT_PS_LO]),
		.expire(expire),
		.countValue(countValue)
	);

	// a clear in the same cycle beats an expiry one cycle old, so a
	// late clear still prevents the imminent timeout
	assign expireHit = expire & cfgEnable & ~clearNow; // see [R5]
	assign wakeNow = (state_q == ST_SLEEP) &&
		(wakeSourceEvent || (expire & cfgEnable));

	// one wait state: pready rises in the second access cycle
	assign apbAccess = psel & penable & pready;
	assign apbWrite = apbAccess & pwrite;

	// hold-clear conditions for the counter
	always @* begin
		clearNow = 1'b0;
		if (!cfgEnable)
			clearNow = 1'b1; // see [R5] (see [R10])
		if (clearWatchdogInstruction)
			clearNow = 1'b1; // see [R8] (see [R10])
		if (oscFailDetect)
			clearNow = 1'b1; // see [R10]
		if (sleepInstruction && state_q == ST_RUN)
			clearNow = 1'b1; // see [R8]
		if (wakeNow)
			clearNow = 1'b1; // see [R12] (see [R10])
		if (state_q == ST_OSTWAIT)
			clearNow = 1'b1; // see [R11]
	end

	// sleep sequencer and flag updates
	always @* begin
		state_d = state_q;
		timeout_d = timeoutFlag;
		powerdown_d = powerdownFlag;
		resetReq_d = 1'b0;
		wakeReq_d = 1'b0;
		case (state_q)
			ST_RUN: begin
				if (sleepInstruction) begin
					state_d = ST_SLEEP;
					powerdown_d = 1'b0; // see [R13]
					timeout_d = 1'b1; // see [R13]
				end else if (expireHit) begin
					resetReq_d = 1'b1; // see [R3]
					timeout_d = 1'b0; // see [R9]
				end
			end
			ST_SLEEP: begin
				// counting continues here with the core clock stopped
				if (wakeNow) begin
					wakeReq_d = 1'b1; // see [R4]
					if (expire & cfgEnable)
						timeout_d = 1'b0; // see [R9]
					if (isCrystal(sysClkMode))
						state_d = ST_OSTWAIT; // see [R11]
					else
						state_d = ST_RUN; // see [R10]
				end
			end
			ST_OSTWAIT: begin
				if (oscillatorStartupTimerDone)
					state_d = ST_RUN; // see [R11]
			end
			default: begin
				state_d = ST_RUN;
			end
		endcase
	end

	assign irqEvents = {(state_q == ST_RUN) & sleepInstruction,
		wakeNow & expire & cfgEnable, resetReq_d};

	// sticky status: a new event wins over a write-one-to-clear
	always @* begin
		irqStat_d = irqStat_q;
		if (apbWrite && isReg(paddr, `WDT_OFS_IRQ_STAT))
			irqStat_d = irqStat_q & ~pwdata[`WDT_IRQ_W-1:0];
		irqStat_d = irqStat_d | irqEvents;
	end

	always @* begin
		option_d = timerOption;
		if (apbWrite && isReg(paddr, `WDT_OFS_OPTION))
			option_d = pwdata[7:0]; // see [R7]
	end

	// read mux; unmapped addresses read zero and flag an error
	always @* begin
		readValue = 32'h0000_0000;
		readHit = 1'b1;
		if (isReg(paddr, `WDT_OFS_OPTION)) begin
			readValue[7:0] = timerOption;
		end else if (isReg(paddr, `WDT_OFS_FLAGS)) begin
			readValue[`WDT_FLG_TIMEOUT] = timeoutFlag;
			readValue[`WDT_FLG_POWERDOWN] = powerdownFlag;
			readValue[`WDT_FLG_SLEEPING] = (state_q == ST_SLEEP);
			readValue[`WDT_FLG_OSTHOLD] = (state_q == ST_OSTWAIT);
			readValue[`WDT_FLG_ENABLED] = cfgEnable;
		end else if (isReg(paddr, `WDT_OFS_IRQ_STAT)) begin
			readValue[`WDT_IRQ_W-1:0] = irqStat_q;
		end else if (isReg(paddr, `WDT_OFS_IRQ_MASK)) begin
			readValue[`WDT_IRQ_W-1:0] = irqMask_q;
		end else if (isReg(paddr, `WDT_OFS_COUNT)) begin
			readValue[`WDT_CNT_W-1:0] = countValue;
		end else begin
			readHit = 1'b0;
		end
	end

	always @(posedge mclk) begin
		if (!rst_n) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else begin
			pready <= psel & penable & ~pready;
			if (psel & penable & ~pready) begin
				pslverr <= ~readHit;
				prdata <= pwrite ? 32'h0000_0000 : readValue;
			end else begin
				pslverr <= 1'b0;
			end
		end
	end

	always @(posedge mclk) begin
		if (!rst_n) begin
			state_q <= ST_RUN; // see [R14]
			timeoutFlag <= 1'b1;
			powerdownFlag <= 1'b1;
			deviceResetReq <= 1'b0;
			wakeRequest <= 1'b0;
			sleeping <= 1'b0;
			timerOption <= `WDT_OPTION_RST;
			irqStat_q <= `WDT_IRQ_RST;
			irqMask_q <= `WDT_MASK_RST;
			irq <= 1'b0;
		end else begin
			state_q <= state_d;
			timeoutFlag <= timeout_d;
			powerdownFlag <= powerdown_d;
			deviceResetReq <= resetReq_d;
			wakeRequest <= wakeReq_d;
			sleeping <= (state_d == ST_SLEEP);
			timerOption <= option_d;
			irqStat_q <= irqStat_d;
			if (apbWrite && isReg(paddr, `WDT_OFS_IRQ_MASK))
				irqMask_q <= pwdata[`WDT_IRQ_W-1:0];
			irq <= |(irqStat_d & irqMask_q);
		end
	end

endmodule

`default_nettype wire

// >>> verif/wdt_top_assertions.sv
/* port-level checker for wdt_top, attached by bind.
   assumes one mclk domain and a synchronous active-low reset. */
`default_nettype none
module wdt_top_assertions #(
	parameter int TIMEOUT_CYCLES = 20
) (
	// clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// apb answer
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic pslverr,
	// core side
	input wire logic clearWatchdogInstruction,
	input wire logic sleepInstruction,
	input wire logic oscFailDetect,
	input wire logic watchdogConfigEnable,
	// results
	input wire logic deviceResetReq,
	input wire logic wakeRequest,
	input wire logic sleeping,
	input wire logic timeoutFlag,
	input wire logic powerdownFlag,
	input wire logic [7:0] timerOption
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_n);
	int gapCnt_q;
	logic cleanRun_q;
	// the gap is only exact when nothing cleared or slowed the count
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			gapCnt_q <= 0;
			cleanRun_q <= 1'b0;
		end else if (deviceResetReq) begin
			gapCnt_q <= 1;
			cleanRun_q <= 1'b1;
		end else begin
			gapCnt_q <= gapCnt_q + 1;
			if (clearWatchdogInstruction || sleeping || timerOption[3] ||
				!watchdogConfigEnable || oscFailDetect)
				cleanRun_q <= 1'b0;
		end
	end
	sequence s_waitState;
		psel && penable && !pready;
	endsequence
	sequence s_offLong;
		!watchdogConfigEnable [*8];
	endsequence
	a_apb_one_wait: assert property (s_waitState |=> pready)
		else $error("pready late");
	a_error_with_ready: assert property (pslverr |-> pready && psel)
		else $error("stray pslverr");
	a_reset_when_run: assert property (deviceResetReq |->
		!sleeping && !timeoutFlag) else $error("bad reset request");
	a_wake_leaves_sleep: assert property (wakeRequest |->
		!sleeping && $past(sleeping)) else $error("bad wake");
	a_sleep_entry_flags: assert property ($rose(sleeping) |->
		$past(sleepInstruction) && !powerdownFlag && timeoutFlag)
		else $error("bad sleep entry");
	a_disabled_silent: assert property (s_offLong |->
		!deviceResetReq && !wakeRequest) else $error("timeout while off");
	a_clear_holds_off: assert property (clearWatchdogInstruction &&
		!sleeping |-> ##4 !deviceResetReq [*8]) else $error("clear lost");
	a_exact_period: assert property (deviceResetReq && cleanRun_q |->
		gapCnt_q == TIMEOUT_CYCLES) else $error("wrong period");
endmodule
bind wdt_top wdt_top_assertions #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) chk (
	.mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable),
	.pready(pready), .pslverr(pslverr),
	.clearWatchdogInstruction(clearWatchdogInstruction),
	.sleepInstruction(sleepInstruction), .oscFailDetect(oscFailDetect),
	.watchdogConfigEnable(watchdogConfigEnable),
	.deviceResetReq(deviceResetReq), .wakeRequest(wakeRequest),
	.sleeping(sleeping), .timeoutFlag(timeoutFlag),
	.powerdownFlag(powerdownFlag), .timerOption(timerOption));
`default_nettype wire

// >>> verif/wdt_top_test.sv
/* self-checking bench for wdt_top: apb reads queued and compared.
   assumes the checker file is compiled with it. */
`default_nettype none
`include "wdt_defines.vh"
module wdt_top_test;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int T = 20;
	logic mclk, rst_n, psel, penable, pwrite, pready, pslverr, irq;
	logic clr, slp, wakeSrc, oscFail, ostDone, cfgEn, rstReq, wakeReq;
	logic [7:0] paddr;
	logic [2:0] clkMode;
	logic [31:0] pwdata, prdata, seed, m;
	logic [32:0] expQ[$];
	int n_errors, comparisons, n, hits;
	wdt_top #(.TIMEOUT_CYCLES(20'(T))) DUT (.mclk(mclk), .rst_n(rst_n),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .clearWatchdogInstruction(clr),
		.sleepInstruction(slp), .wakeSourceEvent(wakeSrc),
		.oscFailDetect(oscFail), .sysClkMode(clkMode),
		.oscillatorStartupTimerDone(ostDone),
		.watchdogConfigEnable(cfgEn), .deviceResetReq(rstReq),
		.wakeRequest(wakeReq), .sleeping(), .timeoutFlag(),
		.powerdownFlag(), .timerOption(), .irq(irq));
	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_errors++;
			$display("Error t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	always @(posedge mclk) begin
		if (psel && penable && pready === 1'b1 && !pwrite) begin
			comparisons++;
			if ({pslverr, prdata} !== expQ[0]) begin
				n_errors++;
				$display("Error t=%0t got %h exp %h", $time,
					{pslverr, prdata}, expQ[0]);
			end
			void'(expQ.pop_front());
		end
	end
	task automatic print_verdict();
		$display("errors %0d comparisons %0d", n_errors, comparisons);
		if (n_errors == 0 && comparisons > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// ends on an idle edge so a following call never re-drives psel at once
	task automatic wr(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int k;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge mclk);
			k++;
		end while (pready !== 1'b1 && k < 10);
		if (pready !== 1'b1) begin
			n_errors++;
			$display("Error t=%0t got %h exp %h", $time, pready, 1'b1);
			print_verdict();
		end
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge mclk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [32:0] e);
		expQ.push_back(e);
		wr(1'b0, a, 32'h0);
	endtask
	task automatic waitFor(input logic isWake, input int lim);
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while ((isWake ? wakeReq : rstReq) !== 1'b1 && n < lim);
		if ((isWake ? wakeReq : rstReq) !== 1'b1) begin
			n_errors++;
			$display("Error t=%0t got %h exp %h", $time, n, lim);
			print_verdict();
		end
	endtask
	task automatic idle(input int c);
		repeat (c) begin
			@(posedge mclk);
			if (rstReq === 1'b1)
				hits++;
		end
	endtask
	// sleep just after a timeout so the two never meet in one cycle
	task automatic sleepNow();
		waitFor(1'b0, 2 * T);
		slp <= 1'b1;
		@(posedge mclk);
		slp <= 1'b0;
	endtask
	initial begin
		{rst_n, psel, penable, pwrite, clr, slp, wakeSrc} = '0;
		{oscFail, ostDone, paddr, pwdata, hits} = '0;
		{n_errors, comparisons} = '0;
		cfgEn = 1'b1;
		clkMode = `WDT_CLK_INTERNAL_RC_CLOCK;
		seed = 32'h53;
		repeat (4) @(posedge mclk);
		rst_n <= 1'b1;
		@(posedge mclk);
		rd(`WDT_OFS_OPTION, 33'h0ff);
		rd(`WDT_OFS_IRQ_STAT, 33'h0);
		rd(8'h20, {1'b1, 32'h0});
		rd(`WDT_OFS_FLAGS, 33'h013);
		$display("end regs");
		wr(1'b1, `WDT_OFS_OPTION, 32'h0);
		for (int i = 0; i < 8; i++) begin
			clr <= 1'b1;
			@(posedge mclk);
			clr <= 1'b0;
			idle(9);
		end
		chk(32'(hits), 32'h0);
		$display("end clear");
		waitFor(1'b0, 2 * T);
		waitFor(1'b0, 2 * T);
		chk(32'(n), 32'(T));
		rd(`WDT_OFS_FLAGS, 33'h012);
		$display("end period");
		m = rnd() & 32'h7;
		wr(1'b1, `WDT_OFS_IRQ_MASK, m);
		rd(`WDT_OFS_IRQ_MASK, {1'b0, m});
		wr(1'b1, `WDT_OFS_IRQ_MASK, 32'h1);
		// earlier timeouts left bit 0 set; clear it just after a timeout
		waitFor(1'b0, 2 * T);
		wr(1'b1, `WDT_OFS_IRQ_STAT, 32'h7);
		chk({31'h0, irq}, 32'h0);
		waitFor(1'b0, 2 * T);
		@(posedge mclk);
		chk({31'h0, irq}, 32'h1);
		wr(1'b1, `WDT_OFS_IRQ_STAT, 32'h1);
		@(posedge mclk);
		chk({31'h0, irq}, 32'h0);
		$display("end irq");
		wr(1'b1, `WDT_OFS_OPTION, 32'h0b);
		waitFor(1'b0, 9 * T);
		waitFor(1'b0, 9 * T);
		chk(32'(n), 32'(8 * T));
		wr(1'b1, `WDT_OFS_OPTION, 32'h0);
		$display("end prescale");
		sleepNow();
		rd(`WDT_OFS_FLAGS, 33'h015);
		waitFor(1'b1, T + 4);
		rd(`WDT_OFS_FLAGS, 33'h010);
		$display("end sleep");
		clkMode <= 3'(rnd() % 3);
		sleepNow();
		wakeSrc <= 1'b1;
		@(posedge mclk);
		wakeSrc <= 1'b0;
		rd(`WDT_OFS_FLAGS, 33'h019);
		idle(2 * T);
		rd(`WDT_OFS_COUNT, 33'h0);
		ostDone <= 1'b1;
		$display("end wake");
		cfgEn <= 1'b0;
		hits = 0;
		idle(3 * T);
		chk(32'(hits), 32'h0);
		rd(`WDT_OFS_COUNT, 33'h0);
		cfgEn <= 1'b1;
		oscFail <= 1'b1;
		idle(8);
		rd(`WDT_OFS_COUNT, 33'h0);
		oscFail <= 1'b0;
		$display("end disable");
		// let the count move off zero, then reset in mid-run
		idle(5);
		rst_n <= 1'b0;
		repeat (4) @(posedge mclk);
		rst_n <= 1'b1;
		@(posedge mclk);
		rd(`WDT_OFS_OPTION, 33'h0ff);
		rd(`WDT_OFS_COUNT, 33'h0);
		rd(`WDT_OFS_FLAGS, 33'h013);
		$display("end reset");
		print_verdict();
	end
endmodule
`default_nettype wire
